//--- csw_pkg.sv
// Constants and carrier types for the communication status word bank.
// Assumes one 200 MHz clock and a plain strobe register port.
package csw_pkg;

  // ****************************************
  // Word indices, used directly as register addresses
  // ****************************************
  localparam logic [7:0] CSW_IDX_ID_FAULT = 8'h04;
  localparam logic [7:0] CSW_IDX_SWITCH = 8'h07;
  localparam logic [7:0] CSW_IDX_LINK = 8'h08;
  localparam logic [7:0] CSW_IDX_SER_CNT = 8'h09;
  localparam logic [7:0] CSW_IDX_SVC_CNT = 8'h0A;
  localparam logic [7:0] CSW_IDX_IRQ_STAT = 8'h20;
  localparam logic [7:0] CSW_IDX_IRQ_MASK = 8'h21;
  localparam logic [7:0] CSW_IDX_MODE = 8'h22;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CSW_ID_CODE_LSB = 8;
  localparam int CSW_SWITCH_BIT = 12;
  localparam int CSW_SER_LSB = 0;
  localparam int CSW_SVC_LSB = 8;

  // ****************************************
  // Codes and reset values
  // ****************************************
  localparam logic [7:0] CSW_ID_NORMAL = 8'h00;
  localparam logic [7:0] CSW_ID_STOPPED = 8'h04;
  localparam logic [3:0] CSW_ERR_NONE = 4'h0;
  localparam logic [3:0] CSW_ERR_PARITY = 4'h1;
  localparam logic [3:0] CSW_ERR_FRAMING = 4'h2;
  localparam logic [3:0] CSW_ERR_OVERRUN = 4'h3;
  localparam logic [3:0] CSW_ERR_TOOL = 4'hF;
  localparam logic [15:0] CSW_WORD_RESET = 16'h0000;
  localparam logic [3:0] CSW_IRQ_RESET = 4'h0;

  // Port operating modes.
  typedef enum logic [1:0] {
    CSW_MODE_NONE = 2'b00,
    CSW_MODE_HOST_LINK = 2'b01,
    CSW_MODE_SERIAL = 2'b10
  } csw_mode_e;

  // Events reported by one serial receiver.
  typedef struct packed {
    logic err_parity;
    logic err_framing;
    logic err_overrun;
    logic tx_enabled;
    logic rx_done;
    logic rx_overflow;
  } csw_port_ev_s;

  // Events reported by the identification function.
  typedef struct packed {
    logic code_valid;
    logic [7:0] code;
    logic stopped_in_comm;
  } csw_id_ev_s;

endpackage : csw_pkg

//--- csw_bank.sv
// Status word bank: identification error code, switch mirror, and
// error, flag and BCD count words for the serial and service ports.
// Assumes error, done, overflow and identification inputs are synchronous single-cycle pulses; switch, tool and tx enable are levels.

// Operation
// - Word 04 high byte: identification error code.
// - Stop during identification communication loads code 04.
// - Word 07 bit 12 follows switch pin 6.
// - Word 08 bits 0-3: serial error code.
// - Word 08 bit 4: serial error flag.
// - Word 08 bit 5: serial transmit enabled.
// - Word 08 bit 6: serial reception completed.
// - Word 08 bit 7: serial reception overflow.
// - Word 08 bits 8-11: service port error code.
// - Service code reads F with tool attached.
// - Word 08 bit 12: service error flag.
// - Word 08 bit 13: service transmit enabled.
// - Word 08 bit 14: service reception completed.
// - Word 08 bit 15: service reception overflow.
// - Word 09: serial reception count, four BCD digits.
// - Word 10: service reception count, four BCD digits.
module csw_bank
  import csw_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Event sources
  input wire csw_id_ev_s id_ev,
  input wire logic switch_pin6,
  input wire csw_port_ev_s ser_ev,
  input wire csw_port_ev_s svc_ev,
  input wire logic svc_tool_attached,
  // Interrupt
  output logic irq
);

  // ****************************************
  // State
  // ****************************************
  logic [7:0] id_code_r;
  logic switch_r;
  logic [15:0] cnt_r [2];
  logic [7:0] flags_r [2];
  logic [3:0] irq_stat_r;
  logic [3:0] irq_mask_r;
  csw_mode_e ser_mode_r;
  csw_mode_e svc_mode_r;
  logic [3:0] irq_set;
  logic [15:0] link_word;
  logic [15:0] rd_nxt;

  // ****************************************
  // Identification error code
  // ****************************************
  // A stop during communication outranks a simultaneous code update.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      id_code_r <= CSW_ID_NORMAL;
    end else if (id_ev.stopped_in_comm) begin
      id_code_r <= CSW_ID_STOPPED;
    end else if (id_ev.code_valid) begin
      id_code_r <= id_ev.code;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      switch_r <= 1'b0;
    end else begin
      switch_r <= switch_pin6;
    end
  end

  // ****************************************
  // Mode selection (software written)
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ser_mode_r <= CSW_MODE_NONE;
      svc_mode_r <= CSW_MODE_NONE;
    end else if (reg_wr && reg_addr == CSW_IDX_MODE) begin
      ser_mode_r <= csw_mode_e'(reg_wdata[1:0]);
      svc_mode_r <= csw_mode_e'(reg_wdata[3:2]);
    end
  end

  // ****************************************
  // Per-port error code, flags and counter
  // ****************************************
  // Index 0 is the serial port, index 1 the service port. Flag byte:
  // [3:0] code, [4] error, [5] tx enabled, [6] rx done, [7] overflow.
  // Error, done and overflow persist until the next error or count
  // restart; the program only reads this area, so there is no clear.
  generate
    for (genvar p = 0; p < 2; p++) begin : g_port
      csw_port_ev_s ev;
      csw_mode_e md;
      logic [15:0] inc;
      assign ev = (p == 0) ? ser_ev : svc_ev;
      assign md = (p == 0) ? ser_mode_r : svc_mode_r;

      // Four-digit BCD increment, rolling 9999 over to 0000.
      always_comb begin
        logic carry;
        carry = 1'b1;
        inc = cnt_r[p];
        for (int d = 0; d < 4; d++) begin
          if (carry) begin
            if (cnt_r[p][d*4 +: 4] == 4'h9) begin
              inc[d*4 +: 4] = 4'h0;
            end else begin
              inc[d*4 +: 4] = cnt_r[p][d*4 +: 4] + 4'h1;
              carry = 1'b0;
            end
          end
        end
      end

      always_ff @(posedge sys_clk) begin
        if (rst) begin
          flags_r[p] <= 8'h00;
        end else begin
          if (ev.err_overrun) begin
            flags_r[p][3:0] <= CSW_ERR_OVERRUN;
            flags_r[p][4] <= 1'b1;
          end else if (ev.err_framing) begin
            flags_r[p][3:0] <= CSW_ERR_FRAMING;
            flags_r[p][4] <= 1'b1;
          end else if (ev.err_parity) begin
            flags_r[p][3:0] <= CSW_ERR_PARITY;
            flags_r[p][4] <= 1'b1;
          end
          // Transmit enable is meaningful in host link or serial mode.
          if (md == CSW_MODE_HOST_LINK || md == CSW_MODE_SERIAL) begin
            flags_r[p][5] <= ev.tx_enabled;
          end else begin
            flags_r[p][5] <= 1'b0;
          end
          if (md != CSW_MODE_SERIAL) begin
            flags_r[p][7:6] <= 2'b00;
          end else begin
            if (ev.rx_done) begin
              flags_r[p][6] <= 1'b1;
            end
            if (ev.rx_overflow) begin
              flags_r[p][7] <= 1'b1;
            end
          end
        end
      end

      always_ff @(posedge sys_clk) begin
        if (rst) begin
          cnt_r[p] <= CSW_WORD_RESET;
        end else if (md != CSW_MODE_SERIAL) begin
          cnt_r[p] <= CSW_WORD_RESET;
        end else if (ev.rx_done) begin
          cnt_r[p] <= inc;
        end
      end

      chk_bcd_digits: assert property (
        @(posedge sys_clk) disable iff (rst)
        cnt_r[p][3:0] <= 4'h9 && cnt_r[p][7:4] <= 4'h9 &&
        cnt_r[p][11:8] <= 4'h9 && cnt_r[p][15:12] <= 4'h9)
        else $error("Reception counter holds a non-BCD digit.");
    end
  endgenerate

  // Service port code is forced while the programming tool is attached.
  always_comb begin
    link_word = {flags_r[1], flags_r[0]};
    if (svc_tool_attached) begin
      link_word[CSW_SVC_LSB +: 4] = CSW_ERR_TOOL;
    end
  end

  // ****************************************
  // Interrupt status and mask
  // ****************************************
  // Bits: 0 serial error, 1 service error, 2 serial rx, 3 service rx.
  assign irq_set = {svc_ev.rx_done, ser_ev.rx_done,
      svc_ev.err_parity | svc_ev.err_framing | svc_ev.err_overrun,
      ser_ev.err_parity | ser_ev.err_framing | ser_ev.err_overrun};

  // A set in the same cycle as a write-one clear wins.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_stat_r <= CSW_IRQ_RESET;
    end else if (reg_wr && reg_addr == CSW_IDX_IRQ_STAT) begin
      irq_stat_r <= (irq_stat_r & ~reg_wdata[3:0]) | irq_set;
    end else begin
      irq_stat_r <= irq_stat_r | irq_set;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_mask_r <= CSW_IRQ_RESET;
    end else if (reg_wr && reg_addr == CSW_IDX_IRQ_MASK) begin
      irq_mask_r <= reg_wdata[3:0];
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // ****************************************
  // Read port
  // ****************************************
  always_comb begin
    rd_nxt = 16'h0000;
    unique case (reg_addr)
      CSW_IDX_ID_FAULT: rd_nxt[CSW_ID_CODE_LSB +: 8] = id_code_r;
      CSW_IDX_SWITCH: rd_nxt[CSW_SWITCH_BIT] = switch_r;
      CSW_IDX_LINK: rd_nxt = link_word;
      CSW_IDX_SER_CNT: rd_nxt = cnt_r[0];
      CSW_IDX_SVC_CNT: rd_nxt = cnt_r[1];
      CSW_IDX_IRQ_STAT: rd_nxt[3:0] = irq_stat_r;
      CSW_IDX_IRQ_MASK: rd_nxt[3:0] = irq_mask_r;
      CSW_IDX_MODE: rd_nxt[3:0] = {svc_mode_r, ser_mode_r};
      default: rd_nxt = 16'h0000;
    endcase
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= CSW_WORD_RESET;
    end else if (reg_rd) begin
      reg_rdata <= rd_nxt;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_id_stop_code: assert property (
    @(posedge sys_clk) disable iff (rst)
    id_ev.stopped_in_comm |=> id_code_r == CSW_ID_STOPPED)
    else $error("Stop during communication did not load code 04.");

  chk_id_code_load: assert property (
    @(posedge sys_clk) disable iff (rst)
    id_ev.code_valid && !id_ev.stopped_in_comm |=>
    id_code_r == $past(id_ev.code))
    else $error("Identification code not loaded.");

  chk_id_fault_read: assert property (
    @(posedge sys_clk) disable iff (rst)
    reg_rd && reg_addr == CSW_IDX_ID_FAULT |=>
    reg_rdata == {$past(id_code_r), 8'h00})
    else $error("Identification code word wrong.");

  chk_switch_follow: assert property (
    @(posedge sys_clk) disable iff (rst)
    reg_rd && reg_addr == CSW_IDX_SWITCH |=>
    reg_rdata == {3'b000, $past(switch_r), 12'h000})
    else $error("Switch mirror word wrong.");

  chk_ser_overrun: assert property (
    @(posedge sys_clk) disable iff (rst)
    ser_ev.err_overrun |=> flags_r[0][4:0] == 5'h13)
    else $error("Serial overrun code or flag wrong.");

  chk_ser_framing: assert property (
    @(posedge sys_clk) disable iff (rst)
    ser_ev.err_framing && !ser_ev.err_overrun |=>
    flags_r[0][4:0] == 5'h12)
    else $error("Serial framing code or flag wrong.");

  chk_ser_error_flag: assert property (
    @(posedge sys_clk) disable iff (rst)
    ser_ev.err_parity && !ser_ev.err_framing && !ser_ev.err_overrun
    |=> flags_r[0][4:0] == 5'h11)
    else $error("Serial parity code or flag wrong.");

  chk_ser_irq_set: assert property (
    @(posedge sys_clk) disable iff (rst)
    ser_ev.err_parity || ser_ev.err_framing || ser_ev.err_overrun
    |=> irq_stat_r[0])
    else $error("Serial error did not set its interrupt status.");

  chk_ser_tx_on: assert property (
    @(posedge sys_clk) disable iff (rst)
    ser_ev.tx_enabled && (ser_mode_r == CSW_MODE_HOST_LINK ||
    ser_mode_r == CSW_MODE_SERIAL) |=> flags_r[0][5])
    else $error("Serial transmit enabled flag not set.");

  chk_ser_rx_done: assert property (
    @(posedge sys_clk) disable iff (rst)
    ser_ev.rx_done && ser_mode_r == CSW_MODE_SERIAL |=> flags_r[0][6])
    else $error("Serial reception completed flag not set.");

  chk_ser_overflow: assert property (
    @(posedge sys_clk) disable iff (rst)
    ser_ev.rx_overflow && ser_mode_r == CSW_MODE_SERIAL |=>
    flags_r[0][7])
    else $error("Serial reception overflow flag not set.");

  chk_svc_framing: assert property (
    @(posedge sys_clk) disable iff (rst)
    svc_ev.err_framing && !svc_ev.err_overrun |=>
    flags_r[1][4:0] == 5'h12)
    else $error("Service framing code or flag wrong.");

  chk_svc_code_read: assert property (
    @(posedge sys_clk) disable iff (rst)
    !svc_tool_attached && reg_rd && reg_addr == CSW_IDX_LINK |=>
    reg_rdata[11:8] == $past(flags_r[1][3:0]))
    else $error("Service error code read wrong.");

  chk_tool_code: assert property (
    @(posedge sys_clk) disable iff (rst)
    svc_tool_attached && reg_rd && reg_addr == CSW_IDX_LINK |=>
    reg_rdata[11:8] == CSW_ERR_TOOL)
    else $error("Service code not F while tool attached.");

  chk_svc_tx_off: assert property (
    @(posedge sys_clk) disable iff (rst)
    !(svc_mode_r == CSW_MODE_HOST_LINK || svc_mode_r == CSW_MODE_SERIAL)
    |=> !flags_r[1][5])
    else $error("Service transmit flag set outside its modes.");

  chk_svc_rx_done: assert property (
    @(posedge sys_clk) disable iff (rst)
    svc_ev.rx_done && svc_mode_r == CSW_MODE_SERIAL |=> flags_r[1][6])
    else $error("Service reception completed flag not set.");

  chk_svc_overflow: assert property (
    @(posedge sys_clk) disable iff (rst)
    svc_ev.rx_overflow && svc_mode_r == CSW_MODE_SERIAL |=>
    flags_r[1][7])
    else $error("Service reception overflow flag not set.");

  chk_rx_mode_gate: assert property (
    @(posedge sys_clk) disable iff (rst)
    ser_mode_r != CSW_MODE_SERIAL ##1 ser_mode_r != CSW_MODE_SERIAL
    |-> flags_r[0][7:6] == 2'b00 && cnt_r[0] == 16'h0000)
    else $error("Serial receive state outside serial mode.");

  chk_svc_mode_gate: assert property (
    @(posedge sys_clk) disable iff (rst)
    svc_mode_r != CSW_MODE_SERIAL ##1 svc_mode_r != CSW_MODE_SERIAL
    |-> flags_r[1][7:6] == 2'b00 && cnt_r[1] == 16'h0000)
    else $error("Service receive state outside serial mode.");

  chk_ser_bcd_carry: assert property (
    @(posedge sys_clk) disable iff (rst)
    ser_ev.rx_done && ser_mode_r == CSW_MODE_SERIAL &&
    cnt_r[0] == 16'h0009 |=> cnt_r[0] == 16'h0010)
    else $error("Serial BCD count did not carry.");

  chk_ser_cnt_read: assert property (
    @(posedge sys_clk) disable iff (rst)
    reg_rd && reg_addr == CSW_IDX_SER_CNT |=>
    reg_rdata == $past(cnt_r[0]))
    else $error("Serial reception count read wrong.");

  chk_svc_rx_count: assert property (
    @(posedge sys_clk) disable iff (rst)
    svc_ev.rx_done && svc_mode_r == CSW_MODE_SERIAL &&
    cnt_r[1] == 16'h0009 |=> cnt_r[1] == 16'h0010 && flags_r[1][6])
    else $error("Service BCD count or done flag wrong.");

  chk_unmapped_zero: assert property (
    @(posedge sys_clk) disable iff (rst)
    reg_rd && reg_addr == 8'h05 ##1 1'b1 |-> reg_rdata == 16'h0000)
    else $error("Unused word did not read zero.");

  chk_rdata_idle: assert property (
    @(posedge sys_clk) disable iff (rst)
    !reg_rd |=> reg_rdata == 16'h0000)
    else $error("Read data did not return to zero.");

endmodule : csw_bank

//--- csw_peer.sv
// Far-side model: serial receivers, identification function and switch.
// Assumes the bank samples these inputs on the rising edge of sys_clk.
module csw_peer
  import csw_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Event outputs
  output csw_id_ev_s id_ev,
  output logic switch_pin6,
  output csw_port_ev_s ser_ev,
  output csw_port_ev_s svc_ev,
  output logic svc_tool_attached
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    id_ev = '0;
    switch_pin6 = 1'b0;
    ser_ev = '0;
    svc_ev = '0;
    svc_tool_attached = 1'b0;
  end

  // Levels change right after an edge and hold until set again.
  task automatic set_lvl(input logic pin, tool, stx, vtx);
    @(posedge sys_clk);
    switch_pin6 <= pin;
    svc_tool_attached <= tool;
    ser_ev.tx_enabled <= stx;
    svc_ev.tx_enabled <= vtx;
  endtask : set_lvl

  // Pulses last one cycle; the transmit level is kept through them.
  task automatic port_pulse(input logic svc, input logic [5:0] ev);
    @(posedge sys_clk);
    if (svc) begin
      svc_ev <= ev | {3'h0, svc_ev.tx_enabled, 2'h0};
    end else begin
      ser_ev <= ev | {3'h0, ser_ev.tx_enabled, 2'h0};
    end
    @(posedge sys_clk);
    svc_ev <= {3'h0, svc_ev.tx_enabled, 2'h0};
    ser_ev <= {3'h0, ser_ev.tx_enabled, 2'h0};
  endtask : port_pulse

  task automatic id_pulse(input logic [7:0] c, input logic stop);
    @(posedge sys_clk);
    id_ev <= '{code_valid: 1'b1, code: c, stopped_in_comm: stop};
    @(posedge sys_clk);
    id_ev <= '0;
  endtask : id_pulse
endmodule : csw_peer

//--- csw_bank_tb.sv
// Testbench for the communication status word bank.
// Assumes csw_pkg, csw_bank and csw_peer are compiled before it.
module csw_bank_tb
  import csw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] EV_PAR = 6'h20;
  localparam logic [5:0] EV_FRM = 6'h10;
  localparam logic [5:0] EV_OVR = 6'h08;
  localparam logic [5:0] EV_RXD = 6'h02;
  localparam logic [5:0] EV_OVF = 6'h01;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic irq;
  csw_id_ev_s id_ev;
  logic switch_pin6;
  csw_port_ev_s ser_ev;
  csw_port_ev_s svc_ev;
  logic svc_tool_attached;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [5:0] errs [3] = '{EV_PAR, EV_FRM, EV_OVR};
  logic [7:0] quiet [7] = '{8'h04, 8'h05, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h30};

  always #2.5 sys_clk = ~sys_clk;

  csw_bank i_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .id_ev(id_ev), .switch_pin6(switch_pin6),
    .ser_ev(ser_ev), .svc_ev(svc_ev),
    .svc_tool_attached(svc_tool_attached), .irq(irq));
  csw_peer i_peer (.sys_clk(sys_clk), .id_ev(id_ev),
    .switch_pin6(switch_pin6), .ser_ev(ser_ev), .svc_ev(svc_ev),
    .svc_tool_attached(svc_tool_attached));

  task automatic check_word(input logic [15:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_bit(input logic got, exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: irq %b, expected %b", $time, got, exp);
    end
  endtask : check_bit

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  // Read data stand only in the cycle after the strobe is taken.
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    check_word(reg_rdata, exp);
  endtask : rd_chk

  task automatic wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  // A hang is cut short well beyond the fewer than two hundred cycles needed.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      wrap_up();
    end
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (quiet[i]) rd_chk(quiet[i], 16'h0000);
    wr(CSW_IDX_SWITCH, 16'hFFFF);
    wr(8'h30, 16'hFFFF);
    wr(CSW_IDX_LINK, 16'hFFFF);
    rd_chk(CSW_IDX_SWITCH, 16'h0000);
    rd_chk(CSW_IDX_LINK, 16'h0000);
    $display("test quiet_bank done");
    i_peer.set_lvl(1'b1, 1'b0, 1'b0, 1'b0);
    rd_chk(CSW_IDX_SWITCH, 16'h1000);
    i_peer.id_pulse(8'h03, 1'b0);
    rd_chk(CSW_IDX_ID_FAULT, 16'h0300);
    i_peer.id_pulse(8'h01, 1'b1);
    rd_chk(CSW_IDX_ID_FAULT, 16'h0400);
    i_peer.set_lvl(1'b0, 1'b0, 1'b0, 1'b0);
    rd_chk(CSW_IDX_SWITCH, 16'h0000);
    $display("test switch_and_id done");
    foreach (errs[i]) begin
      i_peer.port_pulse(1'b0, errs[i]);
      rd_chk(CSW_IDX_LINK, 16'h0011 + 16'(i));
    end
    i_peer.port_pulse(1'b1, EV_FRM);
    rd_chk(CSW_IDX_LINK, 16'h1213);
    i_peer.set_lvl(1'b0, 1'b1, 1'b0, 1'b0);
    rd_chk(CSW_IDX_LINK, 16'h1F13);
    i_peer.set_lvl(1'b0, 1'b0, 1'b0, 1'b0);
    rd_chk(CSW_IDX_LINK, 16'h1213);
    rd_chk(CSW_IDX_IRQ_STAT, 16'h0003);
    check_bit(irq, 1'b0);
    wr(CSW_IDX_IRQ_MASK, 16'h0001);
    check_bit(irq, 1'b1);
    wr(CSW_IDX_IRQ_STAT, 16'h0001);
    check_bit(irq, 1'b0);
    rd_chk(CSW_IDX_IRQ_STAT, 16'h0002);
    wr(CSW_IDX_IRQ_MASK, 16'h000F);
    check_bit(irq, 1'b1);
    rd_chk(CSW_IDX_IRQ_MASK, 16'h000F);
    wr(CSW_IDX_IRQ_STAT, 16'h0002);
    check_bit(irq, 1'b0);
    $display("test errors_and_irq done");
    wr(CSW_IDX_MODE, 16'h000A);
    i_peer.set_lvl(1'b0, 1'b0, 1'b1, 1'b1);
    repeat (12) i_peer.port_pulse(1'b0, EV_RXD);
    repeat (9) i_peer.port_pulse(1'b1, EV_RXD);
    i_peer.port_pulse(1'b1, EV_RXD | EV_OVF);
    i_peer.port_pulse(1'b0, EV_OVF);
    check_bit(irq, 1'b1);
    rd_chk(CSW_IDX_LINK, 16'hF2F3);
    rd_chk(CSW_IDX_LINK, 16'hF2F3);
    rd_chk(CSW_IDX_SER_CNT, 16'h0012);
    rd_chk(CSW_IDX_SVC_CNT, 16'h0010);
    wr(CSW_IDX_MODE, 16'h0005);
    rd_chk(CSW_IDX_LINK, 16'h3233);
    rd_chk(CSW_IDX_SER_CNT, 16'h0000);
    wr(CSW_IDX_MODE, 16'h0000);
    rd_chk(CSW_IDX_LINK, 16'h1213);
    wr(CSW_IDX_MODE, 16'h000F);
    rd_chk(CSW_IDX_MODE, 16'h000F);
    rd_chk(CSW_IDX_LINK, 16'h1213);
    $display("test modes_and_counts done");
    wrap_up();
  end
endmodule : csw_bank_tb
